/* verilog/flc_pkg.sv */
// constants for the frequency-locked loop control block
// Functional notes
// - chill_cycle_off set skips chill cycles
// - on request: run only while peripheral asks
// - request mode off: run whenever enabled, unless standby stops it
// - standby: run only with standby bit set
// - drop locks on wake if clock stopped
// - stable bit freezes fine trim after lock
// - mode bit: zero open, one closed loop
// - enable reads back at once, acts later
// - ratio_error is target minus counted cycles
// - coarse trim writable only in open loop
// - fine trim writable only in open loop
// - coarse steps limited to big step limit
// - fine steps limited to small step limit
// - ref_ratio_target sets output to reference ratio
// - ratio write drops locks, fine to midpoint
// - value and ratio registers reset to zero
// - fetch request refreshes value, raises ready
package flc_pkg;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] STATUS_OFS   = 8'h0C;
  localparam logic [7:0] CONTROL_OFS  = 8'h24;
  localparam logic [7:0] VALUE_OFS    = 8'h28;
  localparam logic [7:0] RATIO_OFS    = 8'h2C;
  localparam logic [7:0] FETCH_OFS    = 8'h30;

  // ==========================================================
  // loop_control fields
  localparam int CTL_ENABLE_BIT  = 1;
  localparam int CTL_MODE_BIT    = 2;
  localparam int CTL_STABLE_BIT  = 3;
  localparam int CTL_DROPLK_BIT  = 4;
  localparam int CTL_STDBY_BIT   = 6;
  localparam int CTL_ONREQ_BIT   = 7;
  localparam int CTL_CHILL_BIT   = 8;
  localparam logic [15:0] CTL_RESET    = 16'h0080;
  localparam logic [15:0] CTL_WR_MASK  = 16'h01DE;

  // ==========================================================
  // value / ratio fields
  localparam int RATIO_ERROR_LSB    = 16;
  localparam int COARSE_LSB  = 10;
  localparam int FINE_LSB    = 0;
  localparam int BIG_TRIM_STEP_LIMIT_LSB   = 26;
  localparam int SMALL_TRIM_STEP_LIMIT_LSB   = 16;
  localparam int TARGET_LSB  = 0;
  localparam logic [31:0] VALUE_RESET = 32'h0000_0000;
  localparam logic [31:0] RATIO_RESET = 32'h0000_0000;
  localparam logic [9:0]  FINE_MID    = 10'h200;
  localparam int FETCH_BIT   = 7;
  localparam int READY_BIT   = 0;

  // ==========================================================
  // timing and loop constants
  localparam logic [1:0]  ENABLE_SYNC_CYC = 2'h3;
  localparam logic [15:0] COARSE_TOL      = 16'h0010;
  localparam logic [15:0] FINE_TOL        = 16'h0001;

  typedef enum logic [1:0] {
    ST_OPEN   = 2'b00,
    ST_COARSE = 2'b01,
    ST_FINE   = 2'b10,
    ST_LOCKED = 2'b11
  } flc_state_e;

endpackage : flc_pkg

/* verilog/flc_sync2.sv */
// two-stage synchroniser for asynchronous inputs
`timescale 1ns/10ps
`default_nettype none
module flc_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule : flc_sync2
`default_nettype wire

/* verilog/flc_top.sv */
// frequency-locked loop control, value and ratio registers
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module flc_top (
  input  wire logic        CLK_I,
  input  wire logic        RESET_N_I,
  input  wire logic [7:0]  ADR_I,
  input  wire logic [31:0] DAT_I,
  input  wire logic        WE_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  output logic      [31:0] DAT_O,
  output logic             ACK_O,
  input  wire logic        PERIPH_REQ_I,
  input  wire logic        STANDBY_I,
  input  wire logic        LOOP_REF_CLK_I,
  input  wire logic        LOOP_OUT_CLK_I,
  output logic             OSC_RUN_O,
  output logic      [5:0]  COARSE_TRIM_O,
  output logic      [9:0]  FINE_TRIM_O,
  output logic             CHILL_ACTIVE_O,
  output logic             COARSE_LOCK_O,
  output logic             FINE_LOCK_O
);
  import flc_pkg::*;

  // ==========================================================
  // input synchronisers
  logic [3:0] pin_s;
  flc_sync2 #(.WIDTH(4)) u_sync (
    .clk_i     (CLK_I),
    .reset_n_i (RESET_N_I),
    .async_i   ({LOOP_OUT_CLK_I, LOOP_REF_CLK_I, STANDBY_I, PERIPH_REQ_I}),
    .sync_o    (pin_s)
  );
  wire req_s     = pin_s[0];
  wire standby_s = pin_s[1];
  wire ref_s     = pin_s[2];
  wire out_s     = pin_s[3];

  // ==========================================================
  // state
  logic [15:0] ctl_q;
  logic [31:0] snap_q;
  logic [5:0]  coarse_q;
  logic [9:0]  fine_q;
  logic [5:0]  big_trim_step_limit_q;
  logic [9:0]  small_trim_step_limit_q;
  logic [15:0] target_q;
  logic        en_eff_q;
  logic [1:0]  sync_cnt_q;
  logic        run_q;
  logic        ref_prev_q;
  logic        out_prev_q;
  logic [15:0] out_cnt_q;
  logic [15:0] ratio_error_q;
  logic        adj_go_q;
  logic        chill_q;
  logic        clock_lock_q;
  logic        fine_lock_q;
  logic        ready_q;
  logic        fetch_pend_q;
  logic        stopped_q;
  logic        standby_prev_q;
  logic        ack_q;
  logic [31:0] dat_q;
  flc_state_e  state_q;
  flc_state_e  state_d;

  // ==========================================================
  // wishbone decode
  wire        req_act   = CYC_I && STB_I;
  wire        wr_fire   = req_act && WE_I && ack_q;
  wire        sel_ctl   = (ADR_I == CONTROL_OFS);
  wire        sel_val   = (ADR_I == VALUE_OFS);
  wire        sel_ratio = (ADR_I == RATIO_OFS);
  wire        sel_fetch = (ADR_I == FETCH_OFS);
  wire        sel_stat  = (ADR_I == STATUS_OFS);
  wire        ctl_wr    = wr_fire && sel_ctl;
  wire        val_wr    = wr_fire && sel_val;
  wire        ratio_wr  = wr_fire && sel_ratio;
  wire        fetch_wr  = wr_fire && sel_fetch && SEL_I[0] && DAT_I[FETCH_BIT];
  wire [31:0] byte_mask = {{8{SEL_I[3]}}, {8{SEL_I[2]}}, {8{SEL_I[1]}}, {8{SEL_I[0]}}};

  wire        ctl_enable = ctl_q[CTL_ENABLE_BIT];
  wire        ctl_closed = ctl_q[CTL_MODE_BIT];
  wire        ctl_stable = ctl_q[CTL_STABLE_BIT];
  wire        ctl_droplk = ctl_q[CTL_DROPLK_BIT];
  wire        ctl_stdby  = ctl_q[CTL_STDBY_BIT];
  wire        ctl_onreq  = ctl_q[CTL_ONREQ_BIT];
  wire        ctl_chill  = ctl_q[CTL_CHILL_BIT];

  wire [31:0] ratio_word = {big_trim_step_limit_q, small_trim_step_limit_q, target_q};
  wire [31:0] ratio_new  = (ratio_word & ~byte_mask) | (DAT_I & byte_mask);
  wire [31:0] live_word  = {ratio_error_q, coarse_q, fine_q};
  wire [31:0] val_new    = (live_word & ~byte_mask) | (DAT_I & byte_mask);
  wire [15:0] ctl_new    = ((ctl_q & ~byte_mask[15:0]) | (DAT_I[15:0] & byte_mask[15:0]))
                           & CTL_WR_MASK;
  // closed loop reads the fetched snapshot
  wire [31:0] val_rd     = ctl_closed ? snap_q : {snap_q[31:16], coarse_q, fine_q};
  wire [31:0] rd_mux     = sel_ctl   ? {16'h0000, ctl_q} :
                           sel_val   ? val_rd :
                           sel_ratio ? ratio_word :
                           sel_stat  ? {31'h0, ready_q} : 32'h0000_0000;

  // ==========================================================
  // oscillator run request
  wire demand_ok = !ctl_onreq || req_s;
  wire run_d     = en_eff_q && demand_ok && (!standby_s || ctl_stdby);
  wire wake      = standby_prev_q && !standby_s;
  wire wake_drop = wake && stopped_q && ctl_droplk;
  wire lose_lock = ratio_wr || wake_drop || !ctl_closed;

  // ==========================================================
  // measurement and step sizes
  wire        ref_rise  = ref_s && !ref_prev_q;
  wire        out_rise  = out_s && !out_prev_q && run_q;
  wire        ratio_error_neg  = ratio_error_q[15];
  wire [15:0] ratio_error_abs  = ratio_error_neg ? 16'(~ratio_error_q + 16'h0001) : ratio_error_q;
  wire [5:0]  c_step    = (ratio_error_abs < {10'h000, big_trim_step_limit_q}) ? ratio_error_abs[5:0] : big_trim_step_limit_q;
  wire [9:0]  f_step    = (ratio_error_abs < {6'h00, small_trim_step_limit_q}) ? ratio_error_abs[9:0] : small_trim_step_limit_q;
  wire [6:0]  c_up      = {1'b0, coarse_q} + {1'b0, c_step};
  wire [6:0]  c_dn      = {1'b0, coarse_q} - {1'b0, c_step};
  wire [10:0] f_up      = {1'b0, fine_q} + {1'b0, f_step};
  wire [10:0] f_dn      = {1'b0, fine_q} - {1'b0, f_step};
  wire [5:0]  coarse_adj = ratio_error_neg ? (c_dn[6] ? 6'h00 : c_dn[5:0])
                                    : (c_up[6] ? 6'h3F : c_up[5:0]);
  wire [9:0]  fine_adj   = ratio_error_neg ? (f_dn[10] ? 10'h000 : f_dn[9:0])
                                    : (f_up[10] ? 10'h3FF : f_up[9:0]);
  wire        adj_live   = adj_go_q && !chill_q && !lose_lock;
  wire        coarse_mv  = adj_live && (state_q == ST_COARSE) && (ratio_error_abs > COARSE_TOL);
  wire        fine_mv    = adj_live && (state_q == ST_FINE) && (ratio_error_abs > FINE_TOL);

  // ==========================================================
  // loop state machine
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_OPEN: begin
        if (ctl_closed) state_d = ST_COARSE;
      end
      ST_COARSE: begin
        if (adj_live && ratio_error_abs <= COARSE_TOL) state_d = ST_FINE;
      end
      ST_FINE: begin
        if (adj_live && ratio_error_abs <= FINE_TOL && ctl_stable) state_d = ST_LOCKED;
      end
      ST_LOCKED: begin
        if (!ctl_stable) state_d = ST_FINE;
      end
      default: state_d = ST_OPEN;
    endcase
    if (!ctl_closed) state_d = ST_OPEN;
    else if (ratio_wr || wake_drop) state_d = ST_COARSE;
  end

  // ==========================================================
  // bus slave
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req_act && !ack_q;
      dat_q <= rd_mux;
    end
  end

  // ==========================================================
  // control and ratio registers
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ctl_q    <= CTL_RESET;
      big_trim_step_limit_q  <= RATIO_RESET[BIG_TRIM_STEP_LIMIT_LSB +: 6];
      small_trim_step_limit_q  <= RATIO_RESET[SMALL_TRIM_STEP_LIMIT_LSB +: 10];
      target_q <= RATIO_RESET[TARGET_LSB +: 16];
    end else begin
      if (ctl_wr) ctl_q <= ctl_new;
      if (ratio_wr) begin
        big_trim_step_limit_q  <= ratio_new[BIG_TRIM_STEP_LIMIT_LSB +: 6];
        small_trim_step_limit_q  <= ratio_new[SMALL_TRIM_STEP_LIMIT_LSB +: 10];
        target_q <= ratio_new[TARGET_LSB +: 16];
      end
    end
  end

  // ==========================================================
  // delayed enable and oscillator run
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      en_eff_q       <= 1'b0;
      sync_cnt_q     <= 2'h0;
      run_q          <= 1'b0;
      stopped_q      <= 1'b0;
      standby_prev_q <= 1'b0;
    end else begin
      if (en_eff_q == ctl_enable) begin
        sync_cnt_q <= 2'h0;
      end else if (sync_cnt_q == ENABLE_SYNC_CYC - 2'h1) begin
        en_eff_q   <= ctl_enable;
        sync_cnt_q <= 2'h0;
      end else begin
        sync_cnt_q <= sync_cnt_q + 2'h1;
      end
      run_q          <= run_d;
      standby_prev_q <= standby_s;
      if (wake) stopped_q <= 1'b0;
      else if (standby_s && !run_q) stopped_q <= 1'b1;
    end
  end

  // ==========================================================
  // cycle counting over one reference period
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ref_prev_q <= 1'b0;
      out_prev_q <= 1'b0;
      out_cnt_q  <= 16'h0000;
      ratio_error_q     <= VALUE_RESET[RATIO_ERROR_LSB +: 16];
      adj_go_q   <= 1'b0;
    end else begin
      ref_prev_q <= ref_s;
      out_prev_q <= out_s;
      adj_go_q   <= ref_rise && ctl_closed && run_q;
      if (ref_rise) begin
        out_cnt_q <= {15'h0000, out_rise};
        if (ctl_closed) ratio_error_q <= target_q - out_cnt_q;
      end else if (out_rise && out_cnt_q != 16'hFFFF) begin
        out_cnt_q <= out_cnt_q + 16'h0001;
      end
    end
  end

  // ==========================================================
  // trims, locks and chill cycles
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      coarse_q     <= VALUE_RESET[COARSE_LSB +: 6];
      fine_q       <= VALUE_RESET[FINE_LSB +: 10];
      state_q      <= ST_OPEN;
      chill_q      <= 1'b0;
      clock_lock_q <= 1'b0;
      fine_lock_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      if (val_wr && !ctl_closed) begin
        coarse_q <= val_new[COARSE_LSB +: 6];
        fine_q   <= val_new[FINE_LSB +: 10];
      end else if (coarse_mv) begin
        coarse_q <= coarse_adj;
      end else if (fine_mv && state_q != ST_LOCKED) begin
        fine_q <= fine_adj;
      end
      if (ratio_wr) fine_q <= FINE_MID;
      if (lose_lock) begin
        clock_lock_q <= 1'b0;
        fine_lock_q  <= 1'b0;
        chill_q      <= 1'b0;
      end else if (adj_go_q) begin
        if (chill_q) chill_q <= 1'b0;
        else chill_q <= (coarse_mv || fine_mv) && !ctl_chill;
        if (state_q == ST_COARSE && ratio_error_abs <= COARSE_TOL) clock_lock_q <= 1'b1;
        if (state_q == ST_FINE && !chill_q) fine_lock_q <= (ratio_error_abs <= FINE_TOL);
      end
    end
  end

  // ==========================================================
  // value fetch
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      snap_q       <= VALUE_RESET;
      ready_q      <= 1'b1;
      fetch_pend_q <= 1'b0;
    end else begin
      if (fetch_wr) begin
        ready_q      <= 1'b0;
        fetch_pend_q <= 1'b1;
      end else if (fetch_pend_q) begin
        snap_q       <= live_word;
        ready_q      <= 1'b1;
        fetch_pend_q <= 1'b0;
      end
    end
  end

  assign DAT_O          = dat_q;
  assign ACK_O          = ack_q;
  assign OSC_RUN_O      = run_q;
  assign COARSE_TRIM_O  = coarse_q;
  assign FINE_TRIM_O    = fine_q;
  assign CHILL_ACTIVE_O = chill_q;
  assign COARSE_LOCK_O  = clock_lock_q;
  assign FINE_LOCK_O    = fine_lock_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);

  wire en_mis = (ctl_enable != en_eff_q);
  sequence fetch_start; fetch_wr; endsequence
  sequence fetch_done; !ready_q ##1 ready_q; endsequence

  chk_chill_skip:    assert property (adj_go_q && chill_q |=> $stable(coarse_q))
    else $error("trim moved in a chill cycle");
  chk_request_stop:  assert property (en_eff_q && ctl_onreq && !req_s |=> !run_q)
    else $error("oscillator runs without a request");
  chk_always_run:    assert property (en_eff_q && !ctl_onreq && !standby_s |=> run_q)
    else $error("enabled oscillator not running");
  chk_standby_stop:  assert property (standby_s && !ctl_stdby |=> !run_q)
    else $error("oscillator runs in standby");
  chk_wake_drop:     assert property (wake_drop |=> !COARSE_LOCK_O && !FINE_LOCK_O)
    else $error("locks kept after wake");
  chk_fine_frozen:   assert property (state_q == ST_LOCKED && !ratio_wr && !val_wr
                                      |=> $stable(fine_q))
    else $error("fine trim moved while frozen");
  chk_open_hold:     assert property (!ctl_closed |=> state_q == ST_OPEN && !COARSE_LOCK_O)
    else $error("loop active in open mode");
  chk_enable_late:   assert property (en_mis [*3] |=> !en_mis)
    else $error("enable not applied after delay");
  chk_enable_early:  assert property ($rose(en_mis) |=> en_mis || $changed(ctl_enable))
    else $error("enable applied too early");
  chk_ratio_error_calc:     assert property (ref_rise && ctl_closed
                                      |=> ratio_error_q == $past(target_q) - $past(out_cnt_q))
    else $error("ratio error wrong");
  chk_coarse_ro:     assert property (ctl_closed && val_wr && !adj_go_q
                                      |=> $stable(coarse_q))
    else $error("coarse written in closed loop");
  chk_fine_ro:       assert property (ctl_closed && val_wr && !adj_go_q && !ratio_wr
                                      |=> $stable(fine_q))
    else $error("fine written in closed loop");
  chk_coarse_step:   assert property (ctl_closed && !$past(val_wr) |->
                                      ((coarse_q >= $past(coarse_q)) ? coarse_q - $past(coarse_q)
                                       : $past(coarse_q) - coarse_q) <= big_trim_step_limit_q)
    else $error("coarse step too large");
  chk_fine_step:     assert property (ctl_closed && !$past(ratio_wr) && !$past(val_wr) |->
                                      ((fine_q >= $past(fine_q)) ? fine_q - $past(fine_q)
                                       : $past(fine_q) - fine_q) <= small_trim_step_limit_q)
    else $error("fine step too large");
  chk_ratio_reset:   assert property (ratio_wr |=> fine_q == FINE_MID && !FINE_LOCK_O)
    else $error("ratio write did not reset loop");
  chk_fetch_ready:   assert property (fetch_start |=> fetch_done)
    else $error("fetch did not raise ready");

endmodule : flc_top
`default_nettype wire

/* tb/flc_top_tb.sv */
// self-checking testbench for the loop control block
`timescale 1ns/10ps
`default_nettype none
module flc_top_tb;
  import flc_pkg::*;

  // ==========================================================
  // stimulus and observed signals
  logic        clk;
  logic        rst_n;
  logic        we;
  logic        cyc;
  logic        stb;
  logic        req;
  logic        stdby;
  logic        ref_clk;
  logic        out_clk;
  logic        ref_run;
  logic [7:0]  adr;
  logic [31:0] dat_w;
  logic [3:0]  sel;
  logic [31:0] rd;
  logic [6:0]  ref_cnt;
  logic [9:0]  f0;
  logic [31:0] dat_r;
  logic        ack;
  logic        osc_run;
  logic        chill;
  logic        c_lock;
  logic        f_lock;
  logic [5:0]  coarse;
  logic [9:0]  fine;
  int          bad_count;
  int          samples_checked;
  int          cycles;
  int          i;

  flc_top i_dut (
    .CLK_I          (clk),
    .RESET_N_I      (rst_n),
    .ADR_I          (adr),
    .DAT_I          (dat_w),
    .WE_I           (we),
    .SEL_I          (sel),
    .CYC_I          (cyc),
    .STB_I          (stb),
    .DAT_O          (dat_r),
    .ACK_O          (ack),
    .PERIPH_REQ_I   (req),
    .STANDBY_I      (stdby),
    .LOOP_REF_CLK_I (ref_clk),
    .LOOP_OUT_CLK_I (out_clk),
    .OSC_RUN_O      (osc_run),
    .COARSE_TRIM_O  (coarse),
    .FINE_TRIM_O    (fine),
    .CHILL_ACTIVE_O (chill),
    .COARSE_LOCK_O  (c_lock),
    .FINE_LOCK_O    (f_lock)
  );

  // ==========================================================
  // clock, loop clocks and hang guard
  always #50 clk = ~clk;

  // output clock rises every 2 cycles, reference period 64 cycles: 32 edges a period
  always @(posedge clk) begin
    out_clk <= ~out_clk;
    ref_cnt <= ref_cnt + 7'h01;
    if (ref_run && ref_cnt[4:0] == 5'h1F) begin
      ref_clk <= ~ref_clk;
    end
    cycles = cycles + 1;
    if (cycles == 30000) begin
      bad_count++;
      finish_test();
    end
  end

  // ==========================================================
  // bus cycle, compare and closing tasks
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    @(posedge clk);
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= w;
    adr   <= a;
    dat_w <= d;
    sel   <= s;
    do @(posedge clk); while (ack !== 1'b1);
    rd = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : wb

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic finish_test;
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test

  // ==========================================================
  // main sequence
  initial begin
    {clk, rst_n, we, cyc, stb, req, stdby, ref_clk, out_clk} = '0;
    // reference runs from the start so the first closed-loop period is whole
    ref_run = 1'b1;
    adr = '0; dat_w = '0; sel = '0; ref_cnt = '0;
    bad_count = 0; samples_checked = 0; cycles = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    wb(1'b0, CONTROL_OFS, 32'h0, 4'hF); chk(rd, 32'h0000_0080);
    wb(1'b0, VALUE_OFS, 32'h0, 4'hF);   chk(rd, 32'h0);
    wb(1'b0, RATIO_OFS, 32'h0, 4'hF);   chk(rd, 32'h0);
    wb(1'b0, STATUS_OFS, 32'h0, 4'hF);  chk(rd, 32'h1);
    wb(1'b1, 8'h04, 32'hFFFF_FFFF, 4'hF);
    wb(1'b0, 8'h04, 32'h0, 4'hF);       chk(rd, 32'h0);
    // control readback and delayed enable
    wb(1'b1, CONTROL_OFS, 32'h0000_FFFF, 4'hF);
    wb(1'b0, CONTROL_OFS, 32'h0, 4'hF); chk(rd, {16'h0, CTL_WR_MASK});
    wb(1'b1, CONTROL_OFS, 32'h0, 4'hF);
    repeat (6) @(posedge clk);          chk(osc_run, 32'h0);
    wb(1'b1, CONTROL_OFS, 32'h2, 4'hF); chk(osc_run, 32'h0);
    wb(1'b0, CONTROL_OFS, 32'h0, 4'hF); chk(rd, 32'h2);
    repeat (6) @(posedge clk);          chk(osc_run, 32'h1);
    // request and standby gating
    wb(1'b1, CONTROL_OFS, 32'h82, 4'hF);
    repeat (6) @(posedge clk);          chk(osc_run, 32'h0);
    req <= 1'b1;
    repeat (6) @(posedge clk);          chk(osc_run, 32'h1);
    stdby <= 1'b1;
    repeat (6) @(posedge clk);          chk(osc_run, 32'h0);
    wb(1'b1, CONTROL_OFS, 32'hC2, 4'hF);
    repeat (6) @(posedge clk);          chk(osc_run, 32'h1);
    stdby <= 1'b0;
    req   <= 1'b0;
    wb(1'b1, CONTROL_OFS, 32'h2, 4'hF);
    // open-loop trims, byte lanes, ratio write
    wb(1'b1, VALUE_OFS, 32'hFFFF_1234, 4'hF);
    wb(1'b0, VALUE_OFS, 32'h0, 4'hF);   chk(rd, 32'h0000_1234);
    chk(coarse, 32'h04);
    chk(fine, 32'h234);
    wb(1'b1, VALUE_OFS, 32'h0000_0055, 4'h1);
    wb(1'b0, VALUE_OFS, 32'h0, 4'hF);   chk(rd, 32'h0000_1255);
    wb(1'b1, RATIO_OFS, 32'h0C05_0040, 4'hF);
    wb(1'b0, RATIO_OFS, 32'h0, 4'hF);   chk(rd, 32'h0C05_0040);
    chk(fine, 32'h200);
    // closed loop, target 64 against 32 counted: coarse climbs by 3
    wb(1'b1, CONTROL_OFS, 32'h6, 4'hF);
    ref_run <= 1'b1;
    for (i = 0; i < 2000 && coarse === 6'h04; i++) @(posedge clk);
    chk(coarse, 32'h07);
    for (i = 0; i < 3 && chill !== 1'b1; i++) @(posedge clk);
    chk(chill, 32'h1);
    wb(1'b1, VALUE_OFS, 32'h0, 4'hF);
    @(posedge clk);
    chk(fine, 32'h200);
    chk({31'h0, coarse === 6'h00}, 32'h0);
    wb(1'b1, FETCH_OFS, 32'h80, 4'hF);
    for (i = 0; i < 20; i++) begin
      wb(1'b0, STATUS_OFS, 32'h0, 4'hF);
      if (rd[READY_BIT] === 1'b1) break;
    end
    chk(rd[READY_BIT], 32'h1);
    wb(1'b0, VALUE_OFS, 32'h0, 4'hF);   chk(rd[31:16], 32'h0020);
    // target 16: coarse lock, fine falls by the step limit, chill off
    wb(1'b1, CONTROL_OFS, 32'h106, 4'hF);
    wb(1'b1, RATIO_OFS, 32'h0C05_0010, 4'hF);
    @(posedge clk);
    chk(c_lock, 32'h0);
    chk(fine, 32'h200);
    for (i = 0; i < 2000 && c_lock !== 1'b1; i++) @(posedge clk);
    chk(c_lock, 32'h1);
    for (i = 0; i < 2000 && fine === 10'h200; i++) @(posedge clk);
    chk(fine, 32'h1FB);
    chk(chill, 32'h0);
    // target 32: fine lock, freeze, lock loss on wake
    wb(1'b1, RATIO_OFS, 32'h0C05_0020, 4'hF);
    for (i = 0; i < 2000 && f_lock !== 1'b1; i++) @(posedge clk);
    chk(f_lock, 32'h1);
    wb(1'b1, CONTROL_OFS, 32'h11E, 4'hF);
    f0 = fine;
    repeat (200) @(posedge clk);        chk(fine, {22'h0, f0});
    ref_run <= 1'b0;
    stdby   <= 1'b1;
    repeat (8) @(posedge clk);          chk(osc_run, 32'h0);
    stdby <= 1'b0;
    repeat (8) @(posedge clk);          chk(f_lock, 32'h0);
    ref_run <= 1'b1;
    for (i = 0; i < 2000 && f_lock !== 1'b1; i++) @(posedge clk);
    wb(1'b1, CONTROL_OFS, 32'h10E, 4'hF);
    ref_run <= 1'b0;
    stdby   <= 1'b1;
    repeat (8) @(posedge clk);
    stdby <= 1'b0;
    repeat (8) @(posedge clk);          chk(f_lock, 32'h1);
    finish_test();
  end

endmodule : flc_top_tb
`default_nettype wire
